// file: tb/adct_chk.sv
`timescale 1ns/100ps
module adct_chk
(
  // clock and reset
  input wire logic                       i_clk,
  input wire logic                       i_sys_rst,
  // outputs watched
  input wire logic                       o_sample_en,
  input wire logic [adct_pkg::RES_W-1:0] o_dac_code,
  input wire logic                       o_calibrating,
  input wire logic                       o_done
);
  import adct_pkg::*;
  // long windows and spans are counted here; delays this long would not unroll
  localparam int WIN_MAX  = SAMPLE_SC * (PT_CC_96 << 3);
  localparam int SPAN_MIN = CONV_STEPS * PT_CC_24 + LOAD_PT;
  localparam int SPAN_MAX = CONV_STEPS * PT_CC_96 + LOAD_PT + 4;
  logic sample_q_r;
  int   win_cnt_r;
  int   span_cnt_r;

  always_ff @(posedge i_clk)
  begin
    sample_q_r <= o_sample_en;
    if (i_sys_rst || !o_sample_en)
      win_cnt_r <= 0;
    else
      win_cnt_r <= win_cnt_r + 1;
  end

  // cycles since the window closed, user conversions only
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || o_done)
      span_cnt_r <= 0;
    else if (sample_q_r && !o_sample_en && !o_calibrating)
      span_cnt_r <= 1;
    else if (span_cnt_r != 0)
      span_cnt_r <= span_cnt_r + 1;
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  property p_done_pulse;
    o_done |=> !o_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done wider than one cycle");
  property p_win_min;
    $rose(o_sample_en) |-> o_sample_en[*8];
  endproperty
  a_win_min: assert property (p_win_min) else $error("sampling window too short");
  property p_win_max;
    o_sample_en |-> win_cnt_r < WIN_MAX;
  endproperty
  a_win_max: assert property (p_win_max) else $error("sampling window too long");
  property p_dac_idle;
    o_sample_en |-> o_dac_code == RES_ZERO;
  endproperty
  a_dac_idle: assert property (p_dac_idle) else $error("trial code during sampling");
  property p_done_quiet;
    o_done |-> !o_sample_en && o_dac_code == RES_ZERO;
  endproperty
  a_done_quiet: assert property (p_done_quiet) else $error("done while converting");
  property p_span_min;
    o_done |-> span_cnt_r >= SPAN_MIN;
  endproperty
  a_span_min: assert property (p_span_min) else $error("conversion span too short");
  property p_span_max;
    span_cnt_r <= SPAN_MAX;
  endproperty
  a_span_max: assert property (p_span_max) else $error("conversion span too long");
  property p_cal_once;
    !o_calibrating |=> !o_calibrating;
  endproperty
  a_cal_once: assert property (p_cal_once) else $error("calibration restarted");
  property p_no_done_cal;
    o_calibrating |-> !o_done;
  endproperty
  a_no_done_cal: assert property (p_no_done_cal) else $error("done during calibration");
  c_done: cover property (o_done);
  c_window: cover property ($rose(o_sample_en));
  c_cal_end: cover property ($fell(o_calibrating));
endmodule

bind adct_ctrl adct_chk u_chk (.i_clk, .i_sys_rst, .o_sample_en, .o_dac_code, .o_calibrating, .o_done);

// file: tb/adct_ctrl_tb.sv
`timescale 1ns/100ps
module adct_ctrl_tb;
  import adct_pkg::*;
  logic             i_clk = 0;
  logic             i_sys_rst = 1;
  logic [CTL_W-1:0] i_ctl_word = CTL_RST;
  logic             i_start = 0;
  logic             i_cmp_hi = 0;
  logic             i_under_range = 0;
  logic             i_over_range = 0;
  logic             o_sample_en, o_busy, o_calibrating, o_done;
  logic [RES_W-1:0] o_dac_code, o_result;
  logic [1:0]       cc [3] = '{CCS_24, CCS_96, CCS_48};
  int               mismatches = 0;
  int               n_checks = 0;
  int               ain = 0;
  int               n;
  logic [RES_W-1:0] exp_q [$];

  adct_ctrl u_dut (.i_clk, .i_sys_rst, .i_ctl_word, .i_start, .i_cmp_hi, .i_under_range, .i_over_range,
    .o_sample_en, .o_dac_code, .o_busy, .o_calibrating, .o_done, .o_result);

  initial
  begin
    forever #2 i_clk = ~i_clk;
  end
  // ideal comparator; input held constant per conversion
  always @(posedge i_clk) #1 i_cmp_hi = (ain >= int'(o_dac_code));

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask

  task automatic tmo(input logic hit, input string msg);
    if (hit)
    begin
      mismatches++;
      $display("MISMATCH t=%0t timeout %s", $time, msg);
      final_report();
    end
  endtask

  task automatic conv(input logic [1:0] ccs, input logic [1:0] scs, input int a, input logic u, input logic o,
                      input logic late);
    int               tcc, tsc, win, tot, b;
    tcc = (ccs == CCS_96) ? PT_CC_96 : (ccs == CCS_48) ? PT_CC_48 : PT_CC_24;
    tsc = tcc << scs;
    b = SAMPLE_SC * tsc + CONV_STEPS * tcc + LOAD_PT;
    // ideal comparator yields the input code; range flags saturate
    exp_q.push_back(u ? RES_ZERO : o ? RES_FULL : RES_W'(a));
    win = 0;
    tot = 0;
    @(posedge i_clk) #1;
    chk(o_busy === 1'b0, "busy before start");
    ain = a;
    i_under_range = u;
    i_over_range = o;
    i_ctl_word = {ccs, scs, 12'h000};
    i_start = 1;
    @(posedge i_clk) #1 i_start = 0;
    while (o_sample_en !== 1'b1 && tot < 20)
    begin
      @(posedge i_clk) #1 tot++;
    end
    tmo(o_sample_en !== 1'b1, "window open");
    chk(o_busy === 1'b1, "busy while sampling");
    while (o_sample_en === 1'b1 && win < 2000)
    begin
      @(posedge i_clk) #1 win++;
    end
    tmo(o_sample_en === 1'b1, "window close");
    // late range flag must be ignored once sampling closed
    i_under_range = u | late;
    while (o_done !== 1'b1 && tot < 9000)
    begin
      @(posedge i_clk) #1 tot++;
    end
    tmo(o_done !== 1'b1, "done");
    tot += win;
    chk(win == SAMPLE_SC * tsc, "window length");
    chk(tot > b && tot <= b + 5, "conversion time");
    chk(o_result === exp_q.pop_front(), "result");
    i_under_range = 0;
    i_over_range = 0;
  endtask

  initial
  begin
    void'($urandom(26));
    repeat (10) @(posedge i_clk);
    #1 i_sys_rst = 0;
    chk(o_calibrating === 1'b1, "calibrating after reset");
    n = 0;
    while (o_calibrating === 1'b1 && n < 20000)
    begin
      @(posedge i_clk) #1 n++;
    end
    chk(o_calibrating === 1'b0, "calibration end");
    tmo(o_calibrating === 1'b1, "calibration");
    $display("test calibration done");
    foreach (cc[i])
      for (int s = 0; s < 4; s++)
        conv(cc[i], 2'(s), $urandom % 1024, 0, 0, 0);
    $display("test clock codes done");
    conv(CCS_24, 2'h0, 0, 0, 0, 0);
    conv(CCS_24, 2'h0, 1023, 0, 0, 0);
    conv(CCS_48, 2'h1, 512, 1, 0, 0);
    conv(CCS_48, 2'h1, 512, 0, 1, 0);
    conv(CCS_24, 2'h0, 300, 0, 0, 1);
    $display("test range done");
    final_report();
  end
endmodule

// file: verilog/adct_ctrl.sv
`timescale 1ns/100ps
// Operation
// (RULE_01) conversion clock from field: 24/96/48 phases
// (RULE_02) software never writes reserved code 01
// (RULE_03) sample clock is 1/2/4/8 conversion clocks
// (RULE_04) sampling window exactly two sample clocks
// (RULE_05) conversion lasts 14 tcc plus window plus 4
// (RULE_06) input ignored after sampling window closes
// (RULE_07) under/over range saturates to 000/3ff
// (RULE_08) every timing counted in phase times
// (RULE_09) calibration sequence runs after reset
// (RULE_10) result written first, then done signalled
module adct_ctrl
(
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_sys_rst,
  // control word and start
  input  wire logic [adct_pkg::CTL_W-1:0]  i_ctl_word,
  input  wire logic                        i_start,
  // comparator side (analog, unsynchronised)
  input  wire logic                        i_cmp_hi,
  input  wire logic                        i_under_range,
  input  wire logic                        i_over_range,
  // analog front end control
  output logic                             o_sample_en,
  output logic [adct_pkg::RES_W-1:0]       o_dac_code,
  // status and result
  output logic                             o_busy,
  output logic                             o_calibrating,
  output logic                             o_done,
  output logic [adct_pkg::RES_W-1:0]       o_result
);
  import adct_pkg::*;

  adct_state_t       state_r;
  logic [CNT_W-1:0]  tcc_r;
  logic [CNT_W-1:0]  tsc_r;
  logic [CNT_W-1:0]  cnt_r;
  logic [4:0]        step_r;
  logic [RES_W-1:0]  sar_r;
  logic [2:0]        cal_r;
  logic              cmp_m_r, cmp_s_r;
  logic              und_m_r, und_s_r;
  logic              ovr_m_r, ovr_s_r;
  logic              und_h_r, ovr_h_r;
  logic              cc_tick;
  logic              pending;

  // phase-time count of one conversion clock
  function automatic logic [CNT_W-1:0] cc_period(input logic [1:0] code);
    case (code)
      CCS_96:  cc_period = CNT_W'(PT_CC_96);  // [RULE_01]
      CCS_48:  cc_period = CNT_W'(PT_CC_48);  // [RULE_01]
      // reserved code falls back to fastest setting [RULE_02]
      default: cc_period = CNT_W'(PT_CC_24);  // [RULE_01]
    endcase
  endfunction

  // analog comparator outputs pass two flops
  always_ff @(posedge i_clk)
  begin
    cmp_m_r <= i_cmp_hi;
    cmp_s_r <= cmp_m_r;
    und_m_r <= i_under_range;
    und_s_r <= und_m_r;
    ovr_m_r <= i_over_range;
    ovr_s_r <= ovr_m_r;
  end

  // timing latched at start so a mid-run write cannot skew it [RULE_08]
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      tcc_r <= CNT_W'(PT_CC_24);
      tsc_r <= CNT_W'(PT_CC_24);
    end
    else if (state_r == ST_IDLE)
    begin
      tcc_r <= cc_period(i_ctl_word[CCS_HI:CCS_LO]);
      tsc_r <= cc_period(i_ctl_word[CCS_HI:CCS_LO]) << i_ctl_word[SCS_HI:SCS_LO];  // [RULE_03]
    end
  end

  // divider restarts on each convert entry, so every step gets a full period
  adct_tick u_cc_tick (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_run     (state_r == ST_CONVERT),
    .i_period  (tcc_r),
    .o_tick    (cc_tick)
  );

  // calibration conversions run back to back after reset [RULE_09]
  assign pending = i_start || (cal_r != 3'h0);

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= '0;
      step_r  <= '0;
      cal_r   <= 3'(CAL_RUNS);
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          cnt_r  <= '0;
          step_r <= '0;
          if (pending)
            state_r <= ST_SAMPLE;
        end
        ST_SAMPLE:
        begin
          // window of two sample clocks [RULE_04]
          if (cnt_r == CNT_W'(SAMPLE_SC * tsc_r - 16'h0001))
          begin
            cnt_r   <= '0;
            state_r <= ST_CONVERT;
          end
          else
            cnt_r <= cnt_r + 16'h0001;
        end
        ST_CONVERT:
        begin
          // fourteen conversion clocks [RULE_05]
          if (cc_tick)
          begin
            if (step_r == 5'(CONV_STEPS - 1))
              state_r <= ST_LOAD;
            step_r <= step_r + 5'h01;
          end
        end
        ST_LOAD:
        begin
          // four phase times to load result [RULE_05]
          if (cnt_r == CNT_W'(LOAD_PT - 1))
            state_r <= ST_DONE;
          cnt_r <= cnt_r + 16'h0001;
        end
        ST_DONE:
        begin
          state_r <= ST_IDLE;
          if (cal_r != 3'h0)
            cal_r <= cal_r - 3'h1;
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // range flags caught only inside the window [RULE_06]
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      und_h_r <= 1'h0;
      ovr_h_r <= 1'h0;
    end
    else if (state_r == ST_SAMPLE)
    begin
      und_h_r <= und_s_r;
      ovr_h_r <= ovr_s_r;
    end
  end

  // successive approximation, msb first; comparator sees held sample [RULE_06]
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || state_r == ST_SAMPLE)
      sar_r <= RES_ZERO;
    else if (state_r == ST_CONVERT && cc_tick && step_r < 5'(RES_W))
      sar_r[RES_W-1-step_r] <= cmp_s_r;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_dac_code <= RES_ZERO;
    else if (state_r == ST_CONVERT && step_r < 5'(RES_W))
      o_dac_code <= sar_r | (RES_W'(1) << (RES_W - 1 - step_r));
    else
      o_dac_code <= RES_ZERO;
  end

  // result loads at end of load phase, done one cycle later [RULE_10]
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      o_result <= RES_ZERO;
    else if (state_r == ST_LOAD && cnt_r == CNT_W'(LOAD_PT - 1))
    begin
      if (und_h_r)
        o_result <= RES_ZERO;  // [RULE_07]
      else if (ovr_h_r)
        o_result <= RES_FULL;  // [RULE_07]
      else
        o_result <= sar_r;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_done        <= 1'h0;
      o_busy        <= 1'h0;
      o_sample_en   <= 1'h0;
      o_calibrating <= 1'h1;
    end
    else
    begin
      o_done        <= (state_r == ST_DONE) && (cal_r == 3'h0);  // [RULE_10]
      o_busy        <= (state_r != ST_IDLE) || pending;
      o_sample_en   <= (state_r == ST_SAMPLE);  // [RULE_04]
      o_calibrating <= (cal_r != 3'h0);  // [RULE_09]
    end
  end
endmodule

// file: verilog/adct_pkg.sv
package adct_pkg;
  // control word field layout
  localparam int CTL_W       = 16;
  localparam int CCS_HI      = 15;
  localparam int CCS_LO      = 14;
  localparam int SCS_HI      = 13;
  localparam int SCS_LO      = 12;
  localparam int RES_W       = 10;
  localparam logic [CTL_W-1:0] CTL_RST = 16'h0000;

  // conversion clock codes
  localparam logic [1:0] CCS_24    = 2'h0;
  localparam logic [1:0] CCS_RSVD  = 2'h1;
  localparam logic [1:0] CCS_96    = 2'h2;
  localparam logic [1:0] CCS_48    = 2'h3;

  // timing in phase times; one i_clk edge is one phase time
  localparam int PT_CC_24    = 24;
  localparam int PT_CC_48    = 48;
  localparam int PT_CC_96    = 96;
  localparam int CONV_STEPS  = 14;
  localparam int SAMPLE_SC   = 2;
  localparam int LOAD_PT     = 4;
  localparam int CNT_W       = 16;
  localparam int CAL_RUNS    = 4;

  localparam logic [RES_W-1:0] RES_ZERO = 10'h000;
  localparam logic [RES_W-1:0] RES_FULL = 10'h3ff;

  typedef enum logic [2:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_LOAD, ST_DONE} adct_state_t;
endpackage

// file: verilog/adct_tick.sv
`timescale 1ns/100ps
// divider: one-cycle tick every i_period clocks while running
module adct_tick
(
  // clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_sys_rst,
  // control
  input  wire logic                        i_run,
  input  wire logic [adct_pkg::CNT_W-1:0]  i_period,
  // tick
  output logic                             o_tick
);
  import adct_pkg::*;

  logic [CNT_W-1:0] cnt_r;

  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !i_run)
    begin
      cnt_r  <= '0;
      o_tick <= 1'h0;
    end
    else if (cnt_r == i_period - 16'h0001)
    begin
      cnt_r  <= '0;
      o_tick <= 1'h1;
    end
    else
    begin
      cnt_r  <= cnt_r + 16'h0001;
      o_tick <= 1'h0;
    end
  end
endmodule
